//--- pef_ack_timer.sv
// Acknowledge supervision timer with restart, stop and expiry pulse
`timescale 1ns/100ps
`include "pef_map.svh"

module pef_ack_timer
  import pef_pkg::*;
#(
  parameter int unsigned CYCLES = `PEF_SUP_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic timStart,
  input  wire logic timStop,
  // Status
  output logic      timExpire
);

  typedef struct packed {
    logic        running;
    logic [23:0] cnt;
    logic        expire;
  } pef_tim_t;

  localparam logic [23:0] RELOAD = 24'(CYCLES - 1);

  pef_tim_t st_r;
  pef_tim_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.expire = 1'b0;
    if (timStart) begin
      st_nxt.running = 1'b1;
      st_nxt.cnt     = RELOAD;
    end else if (timStop) begin
      st_nxt.running = 1'b0;
    end else if (st_r.running) begin
      if (st_r.cnt == 24'h000000) begin
        st_nxt.running = 1'b0;
        st_nxt.expire  = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 24'h000001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timExpire = st_r.expire;

endmodule

//--- pef_framer.sv
// Protocol error cause element framer and acknowledge supervision
`timescale 1ns/100ps
`include "pef_map.svh"

module pef_framer
  import pef_pkg::*;
#(
  parameter int unsigned SUP_CYCLES = `PEF_SUP_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Role
  input  wire logic       exchangeRole,
  // Error report request
  input  wire logic       errReq,
  input  wire logic [6:0] errCause,
  input  wire logic [7:0] errMsgType,
  input  wire logic [7:0] errIeId,
  output logic            errReady,
  output logic            errReject,
  // Element octet stream
  output logic [7:0]      ieByte,
  output logic            ieValid,
  output logic            ieLast,
  input  wire logic       ieReady,
  // Received element length check
  input  wire logic       rxLenCheck,
  input  wire logic [7:0] rxLen,
  output logic            rxMalformed,
  // Switch-over management primitives
  input  wire logic       swStart,
  input  wire logic       swPreempt,
  input  wire logic       swGroupOne,
  input  wire logic       swPrefValid,
  input  wire logic [7:0] swPrefChan,
  output logic            swBusy,
  output logic            swReject,
  output logic            supError,
  // Outgoing switch-over message
  output logic            msgSend,
  output logic            msgRetx,
  output logic [1:0]      msgKind,
  output logic            msgPrefValid,
  output logic [7:0]      msgPrefChan,
  // Peer acknowledgement and commands
  input  wire logic       ackRcvd,
  input  wire logic       cmdRcvd,
  input  wire logic       resourceOk,
  output logic            cmdAccept,
  output logic            cmdRefuse
);

  typedef struct packed {
    pef_fr_t   fr;
    logic [6:0] cause;
    logic [7:0] msgType;
    logic [7:0] ieId;
    logic [1:0] dlen;
    logic [7:0] byteOut;
    logic       errRej;
    logic       rxBad;
    pef_sup_t  sup;
    logic       retried;
    pef_kind_t kind;
    logic       prefValid;
    logic [7:0] prefChan;
    logic       send;
    logic       retx;
    logic       supErr;
    logic       swRej;
    logic       accept;
    logic       refuse;
  } pef_state_t;

  pef_state_t st_r;
  pef_state_t st_nxt;
  logic       timStart;
  logic       timStop;
  logic       timExpire;

  function automatic logic causeLegal(input logic [6:0] c);
    unique case (c)
      `PEF_C_DISCRIM, `PEF_C_MSG_TYPE, `PEF_C_IE_MISSING, `PEF_C_IE_UNKNOWN,
      `PEF_C_IE_CONTENT, `PEF_C_STATE, `PEF_C_IE_REPEAT, `PEF_C_IE_TOO_MANY,
      `PEF_C_LCID: causeLegal = 1'b1;
      default:     causeLegal = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] diagLen(input logic [6:0] c);
    unique case (c)
      `PEF_C_MSG_TYPE, `PEF_C_STATE, `PEF_C_IE_TOO_MANY: diagLen = 2'h1;
      `PEF_C_IE_MISSING, `PEF_C_IE_UNKNOWN, `PEF_C_IE_CONTENT,
      `PEF_C_IE_REPEAT: diagLen = 2'h2;
      default: diagLen = 2'h0;
    endcase
  endfunction

  always_comb begin
    st_nxt        = st_r;
    st_nxt.errRej = 1'b0;
    st_nxt.rxBad  = 1'b0;
    st_nxt.send   = 1'b0;
    st_nxt.retx   = 1'b0;
    st_nxt.supErr = 1'b0;
    st_nxt.swRej  = 1'b0;
    st_nxt.accept = 1'b0;
    st_nxt.refuse = 1'b0;
    timStart      = 1'b0;
    timStop       = 1'b0;

    // Framer, one octet per accepted beat
    unique case (st_r.fr)
      FR_IDLE: begin
        if (errReq) begin
          if (exchangeRole || !causeLegal(errCause)) begin
            st_nxt.errRej = 1'b1;
          end else begin
            st_nxt.fr      = FR_ID;
            st_nxt.cause   = errCause;
            st_nxt.msgType = errMsgType;
            st_nxt.ieId    = errIeId;
            st_nxt.dlen    = diagLen(errCause);
            st_nxt.byteOut = `PEF_IEI;
          end
        end
      end
      FR_ID: begin
        if (ieReady) begin
          st_nxt.fr      = FR_LEN;
          st_nxt.byteOut = {6'h00, st_r.dlen} + 8'h01;
        end
      end
      FR_LEN: begin
        if (ieReady) begin
          st_nxt.fr      = FR_CAUSE;
          st_nxt.byteOut = {1'b1, st_r.cause};
        end
      end
      FR_CAUSE: begin
        if (ieReady) begin
          st_nxt.fr      = (st_r.dlen == 2'h0) ? FR_IDLE : FR_DIAG1;
          st_nxt.byteOut = st_r.msgType;
        end
      end
      FR_DIAG1: begin
        if (ieReady) begin
          st_nxt.fr      = (st_r.dlen == 2'h2) ? FR_DIAG2 : FR_IDLE;
          st_nxt.byteOut = st_r.ieId;
        end
      end
      FR_DIAG2: begin
        if (ieReady) begin
          st_nxt.fr = FR_IDLE;
        end
      end
      default: st_nxt.fr = FR_IDLE;
    endcase

    if (rxLenCheck) begin
      st_nxt.rxBad = (rxLen < {5'h00, `PEF_LEN_MIN}) || (rxLen > {5'h00, `PEF_LEN_MAX});
    end

    // verify resources only, no completion message
    if (cmdRcvd && !exchangeRole) begin
      st_nxt.accept = resourceOk;
      st_nxt.refuse = !resourceOk;
    end

    // Supervision of awaited acknowledgement
    unique case (st_r.sup)
      SUP_NULL: begin
        if (swStart) begin
          if (exchangeRole && swPreempt && swGroupOne) begin
            st_nxt.swRej = 1'b1;
          end else begin
            st_nxt.sup       = SUP_WAIT;
            st_nxt.retried   = 1'b0;
            st_nxt.send      = 1'b1;
            timStart         = 1'b1;
            st_nxt.kind      = !exchangeRole ? MSG_SW_REQ :
                               (swPreempt ? MSG_SW_PREEMPT : MSG_SW_COM);
            st_nxt.prefValid = exchangeRole ? 1'b1 : swPrefValid;
            st_nxt.prefChan  = swPrefChan;
          end
        end
      end
      SUP_WAIT: begin
        if (ackRcvd) begin
          st_nxt.sup     = SUP_NULL;
          st_nxt.retried = 1'b0;
          timStop        = 1'b1;
        end else if (timExpire) begin
          if (!st_r.retried) begin
            st_nxt.retried = 1'b1;
            st_nxt.send    = 1'b1;
            st_nxt.retx    = 1'b1;
            timStart       = 1'b1;
          end else begin
            st_nxt.supErr  = 1'b1;
            st_nxt.sup     = SUP_NULL;
            st_nxt.retried = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  pef_ack_timer #(
    .CYCLES (SUP_CYCLES)
  ) u_timer (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .timStart  (timStart),
    .timStop   (timStop),
    .timExpire (timExpire)
  );

  // Handshakes combinational, data from flip-flops
  assign errReady     = (st_r.fr == FR_IDLE);
  assign errReject    = st_r.errRej;
  assign ieByte       = st_r.byteOut;
  assign ieValid      = (st_r.fr != FR_IDLE);
  assign ieLast       = ((st_r.fr == FR_CAUSE) && (st_r.dlen == 2'h0)) ||
                        ((st_r.fr == FR_DIAG1) && (st_r.dlen == 2'h1)) ||
                        (st_r.fr == FR_DIAG2);
  assign rxMalformed  = st_r.rxBad;
  assign swBusy       = (st_r.sup == SUP_WAIT);
  assign swReject     = st_r.swRej;
  assign supError     = st_r.supErr;
  assign msgSend      = st_r.send;
  assign msgRetx      = st_r.retx;
  assign msgKind      = st_r.kind;
  assign msgPrefValid = st_r.prefValid;
  assign msgPrefChan  = st_r.prefChan;
  assign cmdAccept    = st_r.accept;
  assign cmdRefuse    = st_r.refuse;

  // Octet count of the element in flight, for checking only
  logic [2:0] beatCnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !ieValid) begin
      beatCnt <= 3'h1;
    end else if (ieReady) begin
      beatCnt <= beatCnt + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_ACCESS_ONLY: assert property (
    $rose(ieValid) |-> !$past(exchangeRole))
    else $error("Element started on exchange side");
  AST_LEN_RANGE: assert property (
    ieValid && ieReady && ieLast |-> beatCnt >= `PEF_LEN_MIN && beatCnt <= `PEF_LEN_MAX)
    else $error("Element length out of range");
  AST_NO_DIAG_LEN: assert property (
    ieValid && ieReady && ieLast && st_r.dlen == 2'h0 |-> beatCnt == 3'h3)
    else $error("Element without diagnostic not three octets");
  AST_DIAG_LEN: assert property (
    ieValid && ieReady && ieLast && st_r.dlen != 2'h0 |-> beatCnt == 3'h3 + {1'b0, st_r.dlen})
    else $error("Element with diagnostic wrong length");
  AST_DIAG_COPY: assert property (
    st_r.fr == FR_DIAG1 |-> ieByte == st_r.msgType)
    else $error("Diagnostic does not copy message type");
  AST_EXT_BIT: assert property (
    st_r.fr == FR_CAUSE |-> ieByte[`PEF_EXT_BIT] && ieByte[6:0] == st_r.cause)
    else $error("Cause octet malformed");
  AST_DLEN_MAP: assert property (
    errReq && errReady && !exchangeRole && errCause == `PEF_C_IE_REPEAT |=> st_r.dlen == 2'h2)
    else $error("Wrong diagnostic length for repeated element");
  AST_PREEMPT_G1: assert property (
    swStart && !swBusy && exchangeRole && swPreempt && swGroupOne |=> swReject && !msgSend)
    else $error("Pre-emption allowed in group one");
  AST_CMD_REPLY: assert property (
    cmdRcvd && !exchangeRole |=> cmdAccept == $past(resourceOk) && cmdAccept != cmdRefuse)
    else $error("Command answer wrong");
  AST_RETX_ONCE: assert property (
    swBusy && timExpire && !ackRcvd && !st_r.retried |=> msgSend && msgRetx && swBusy)
    else $error("No retransmission on first expiry");
  AST_SECOND_EXP: assert property (
    swBusy && timExpire && !ackRcvd && st_r.retried |=> supError && !msgSend && !swBusy)
    else $error("Second expiry not reported");
  AST_ACK_CLEAR: assert property (
    swBusy && ackRcvd |=> !swBusy && !st_r.retried ##1 !timExpire)
    else $error("Acknowledgement did not stop supervision");

  COV_DIAG_TWO: cover property (ieValid && ieReady && ieLast && st_r.dlen == 2'h2);
  COV_RETX: cover property (msgSend && msgRetx);
  COV_GIVE_UP: cover property (supError);
  COV_ACK: cover property (swBusy && ackRcvd);

endmodule

//--- pef_map.svh
// Constant map for the protection error cause framer
`ifndef PEF_MAP_SVH
`define PEF_MAP_SVH

// Element identifier, extension bit and element length bounds
`define PEF_IEI           8'h53
`define PEF_EXT_BIT       7
`define PEF_LEN_MIN       3'h3
`define PEF_LEN_MAX       3'h5
`define PEF_HDR_OCTETS    3'h3

// Cause codes, seven bits
`define PEF_C_DISCRIM     7'h01
`define PEF_C_MSG_TYPE    7'h04
`define PEF_C_IE_MISSING  7'h07
`define PEF_C_IE_UNKNOWN  7'h08
`define PEF_C_IE_CONTENT  7'h09
`define PEF_C_STATE       7'h0b
`define PEF_C_IE_REPEAT   7'h0c
`define PEF_C_IE_TOO_MANY 7'h0d
`define PEF_C_LCID        7'h0f

// Acknowledge supervision timing
`define PEF_CLK_MHZ       200
`define PEF_SUP_TIME_US   1000
`define PEF_SUP_CYCLES    (`PEF_SUP_TIME_US * `PEF_CLK_MHZ)

`endif

//--- pef_peer_model.sv
// Peer entity model: octet sink with stalls, acknowledgement of switch-over messages
`timescale 1ns/100ps

module pef_peer_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Element octet stream
  input  wire logic       ieValid,
  output logic            ieReady,
  input  wire logic       stall,
  // Switch-over acknowledgement
  input  wire logic       msgSend,
  input  wire logic       ackEn,
  input  wire logic [5:0] ackDly,
  output logic            ackRcvd
);
  typedef struct packed {
    logic [1:0] ph;
    logic       run;
    logic [5:0] cnt;
    logic       ack;
  } pef_peer_st_t;
  pef_peer_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ph = st_r.ph + 2'h1;
    st_nxt.ack = 1'b0;
    // explicit acknowledgement
    // Counts from the first send only, so a late ack can land after a resend
    if (!st_r.run && msgSend && ackEn) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = 6'h00;
    end else if (st_r.run) begin
      st_nxt.cnt = st_r.cnt + 6'h01;
      if (st_r.cnt == ackDly) begin
        st_nxt.ack = 1'b1;
        st_nxt.run = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  // ack withheld when disabled; no completion message exists
  assign ackRcvd = st_r.ack;
  // Low one cycle in four while stalling
  assign ieReady = !stall || (st_r.ph != 2'h0);
endmodule

//--- pef_pkg.sv
// Types shared by the protection error cause framer
package pef_pkg;

  typedef enum logic [2:0] {
    FR_IDLE,
    FR_ID,
    FR_LEN,
    FR_CAUSE,
    FR_DIAG1,
    FR_DIAG2
  } pef_fr_t;

  typedef enum logic {
    SUP_NULL,
    SUP_WAIT
  } pef_sup_t;

  typedef enum logic [1:0] {
    MSG_NONE,
    MSG_SW_REQ,
    MSG_SW_COM,
    MSG_SW_PREEMPT
  } pef_kind_t;

endpackage

//--- protection_error_cause_framer_tb.sv
// Self-checking bench for the error cause framer and supervision
`timescale 1ns/100ps

module protection_error_cause_framer_tb;
  import pef_pkg::*;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin nMismatch++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
  `define WT(c) begin for (w = 0; w < 100 && !(c); w++) @(negedge core_clk); \
    if (!(c)) begin nMismatch++; stopTest(); end end
  logic core_clk = 0, sys_rst = 1, exchangeRole = 0, errReq = 0, ieReady, ieValid, ieLast;
  logic errReady, errReject, rxLenCheck = 0, rxMalformed, swStart = 0, swPreempt = 0;
  logic swGroupOne = 0, swPrefValid = 0, swBusy, swReject, supError, msgSend, msgRetx;
  logic msgPrefValid, ackRcvd, cmdRcvd = 0, resourceOk = 0, cmdAccept, cmdRefuse;
  logic ackEn = 0, stall = 0;
  logic [6:0] errCause = '0;
  logic [7:0] errMsgType = '0, errIeId = '0, ieByte, rxLen = '0, swPrefChan = '0, msgPrefChan;
  logic [5:0] ackDly = '0;
  logic [1:0] msgKind;
  logic [6:0] cs [11] = '{7'h01, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0b, 7'h0c, 7'h0d, 7'h0f,
                          7'h00, 7'h7f};
  int nMismatch = 0, checks = 0, nSend = 0, nErr = 0, w;

  always #2.5 core_clk = ~core_clk;

  pef_framer #(.SUP_CYCLES(20)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .exchangeRole(exchangeRole), .errReq(errReq), .errCause(errCause),
    .errMsgType(errMsgType), .errIeId(errIeId), .errReady(errReady), .errReject(errReject),
    .ieByte(ieByte), .ieValid(ieValid), .ieLast(ieLast), .ieReady(ieReady),
    .rxLenCheck(rxLenCheck), .rxLen(rxLen), .rxMalformed(rxMalformed), .swStart(swStart),
    .swPreempt(swPreempt), .swGroupOne(swGroupOne), .swPrefValid(swPrefValid),
    .swPrefChan(swPrefChan), .swBusy(swBusy), .swReject(swReject), .supError(supError),
    .msgSend(msgSend), .msgRetx(msgRetx), .msgKind(msgKind), .msgPrefValid(msgPrefValid),
    .msgPrefChan(msgPrefChan), .ackRcvd(ackRcvd), .cmdRcvd(cmdRcvd),
    .resourceOk(resourceOk), .cmdAccept(cmdAccept), .cmdRefuse(cmdRefuse));

  pef_peer_model peer (.core_clk(core_clk), .sys_rst(sys_rst), .ieValid(ieValid),
    .ieReady(ieReady), .stall(stall), .msgSend(msgSend), .ackEn(ackEn), .ackDly(ackDly),
    .ackRcvd(ackRcvd));

  always @(posedge core_clk) begin
    if (!sys_rst) begin
      nSend += msgSend;
      nErr += supError;
    end
  end

  task automatic stopTest();
    $display("mismatches %0d checks %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Diagnostic octets per cause; -1 marks a reserved code
  function automatic int dlen(input logic [6:0] c);
    case (c)
      7'h01, 7'h0f: return 0;
      7'h04, 7'h0b, 7'h0d: return 1;
      7'h07, 7'h08, 7'h09, 7'h0c: return 2;
      default: return -1;
    endcase
  endfunction

  task automatic frame(input logic [6:0] c);
    logic [7:0] q [$];
    int dl, k;
    dl = dlen(c);
    @(negedge core_clk);
    `CHK(errReady, 1'b1)
    errCause = c;
    errMsgType = 8'($urandom);
    errIeId = 8'($urandom);
    errReq = 1;
    q = '{8'h53, 8'(1 + dl), {1'b1, c}};
    if (dl > 0) q.push_back(errMsgType);
    if (dl > 1) q.push_back(errIeId);
    @(negedge core_clk);
    errReq = 0;
    if (dl < 0 || exchangeRole) begin
      `CHK(errReject, 1'b1)
      `CHK(ieValid, 1'b0)
      return;
    end
    for (k = 0; k < 100 && q.size() > 0; k++) begin
      if (ieValid && ieReady) begin
        `CHK(ieByte, q[0])
        `CHK(ieLast, q.size() == 1)
        void'(q.pop_front());
      end
      @(negedge core_clk);
    end
    `CHK(q.size(), 0)
    if (q.size() > 0) stopTest();
  endtask

  task automatic sw(input logic pre, grp, pv, input logic [7:0] ch);
    @(negedge core_clk);
    swStart = 1;
    swPreempt = pre;
    swGroupOne = grp;
    swPrefValid = pv;
    swPrefChan = ch;
    @(negedge core_clk);
    swStart = 0;
  endtask

  initial begin
    void'($urandom(32'h5ae4cbb8));
    repeat (20) @(negedge core_clk);
    `CHK({errReady, swBusy, ieValid, msgKind}, 5'h10)
    sys_rst = 0;
    stall = 1;
    foreach (cs[i]) frame(cs[i]);
    repeat (8) frame(7'($urandom));
    exchangeRole = 1;
    frame(7'h08);
    for (int n = 0; n < 8; n++) begin
      @(negedge core_clk);
      rxLenCheck = 1;
      rxLen = n[7:0];
      @(negedge core_clk);
      rxLenCheck = 0;
      `CHK(rxMalformed, n < 3 || n > 5)
    end
    // Access side, no acknowledgement: one resend then error
    exchangeRole = 0;
    nSend = 0;
    sw(1, 0, 1, 8'h5c);
    `CHK({msgSend, msgRetx, swBusy, msgKind}, 5'h15)
    `CHK({msgPrefValid, msgPrefChan}, 9'h15c)
    `WT(msgRetx)
    `CHK(msgSend, 1'b1)
    `WT(supError)
    `CHK(swBusy, 1'b0)
    repeat (30) @(negedge core_clk);
    `CHK(nSend, 2)
    // Late ack after the resend, then a fresh run resends again
    ackEn = 1;
    ackDly = 6'd25;
    nSend = 0;
    nErr = 0;
    sw(0, 0, 0, 8'h00);
    `WT(!swBusy)
    `CHK({nSend, nErr}, {32'd2, 32'd0})
    ackEn = 0;
    nSend = 0;
    sw(0, 0, 0, 8'h00);
    `WT(supError)
    `CHK(nSend, 2)
    // Prompt ack, second start while busy ignored
    ackEn = 1;
    ackDly = 6'd2;
    nSend = 0;
    sw(0, 0, 0, 8'h00);
    sw(0, 0, 0, 8'h00);
    `WT(!swBusy)
    `CHK(nSend, 1)
    // Exchange side pre-emption, then commands on access and exchange side
    exchangeRole = 1;
    sw(1, 1, 0, 8'h00);
    `CHK({swReject, msgSend}, 2'h2)
    sw(1, 0, 1, 8'h21);
    `CHK({msgSend, msgKind}, 3'h7)
    `WT(!swBusy)
    sw(0, 1, 1, 8'h22);
    `CHK({msgSend, msgKind, msgPrefChan}, 11'h622)
    `WT(!swBusy)
    for (int i = 0; i < 3; i++) begin
      exchangeRole = (i == 2);
      @(negedge core_clk);
      cmdRcvd = 1;
      resourceOk = i[0];
      @(negedge core_clk);
      cmdRcvd = 0;
      `CHK({cmdAccept, cmdRefuse}, (i == 2) ? 2'h0 : {i[0], !i[0]})
    end
    stopTest();
  end
endmodule
